// File: rtl/panel_power_pkg.sv
package panel_power_pkg;

  // ----------------------------------------------------------------
  // Power-down mode codes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_SYSTEM    = 2'h0;
  localparam logic [1:0] MODE_DISP_IDLE = 2'h1;
  localparam logic [1:0] MODE_GEN_EXT   = 2'h2;
  localparam logic [1:0] MODE_GEN_INT   = 2'h3;

  // ----------------------------------------------------------------
  // Reset values and synchroniser depth
  // ----------------------------------------------------------------
  localparam logic       PANEL_SEL_RST  = 1'h1;
  localparam logic       SLEEP_REQ_RST  = 1'h1;
  localparam logic [1:0] MODE_RST       = MODE_SYSTEM;
  localparam int         SYNC_STAGES    = 2;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN  = 2'h1,
    ST_DOWN = 2'h2
  } pd_state_t;

  // ----------------------------------------------------------------
  // Pin groups
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] data;
    logic        data_oe;
    logic        iochrdy;
    logic        irq;
    logic        memcs16;
    logic        bios_rom_enable;
    logic        high_byte_buffer_dir;
    logic        low_byte_buffer_dir;
  } host_t;

  typedef struct packed {
    logic        row_strobe_upper;
    logic        row_strobe_lower;
    logic        col_strobe_upper;
    logic        col_strobe_lower;
    logic        dram_out_enable_upper;
    logic        dram_out_enable_lower;
    logic [3:0]  write_strobe;
    logic [8:0]  dram_address;
    logic [15:0] video_mem_data;
    logic        video_mem_oe;
  } mem_t;

  typedef struct packed {
    logic [3:0] upper_half_pixels;
    logic [3:0] lower_half_pixels;
    logic       ac_toggle_signal;
    logic       vertical_strobe;
    logic       horizontal_strobe;
    logic       panel_shift_clock;
    logic       weight_clock;
  } panel_t;

  typedef struct packed {
    logic       palette_read_strobe;
    logic       palette_write_strobe;
    logic       pixel_clock;
    logic [2:0] colour;
  } dac_t;

  localparam host_t  HOST_RST  = '0;
  localparam mem_t   MEM_RST   = '0;
  localparam panel_t PANEL_RST = '0;
  localparam dac_t   DAC_RST   = '0;

endpackage

// File: rtl/level_sync.sv
`timescale 1ns/10ps
`default_nettype none
module level_sync #(
  parameter int   STAGES    = 2,
  parameter logic RST_VALUE = 1'h0
) (
  input  wire logic i_sys_clk,
  input  wire logic i_arst_n,
  input  wire logic i_async,
  output var  logic o_sync
);

  logic [STAGES-1:0] chain;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      chain <= {STAGES{RST_VALUE}};
    end else begin
      chain <= {chain[STAGES-2:0], i_async};
    end
  end

  assign o_sync = chain[STAGES-1];

endmodule
`default_nettype wire

// File: rtl/panel_power_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module panel_power_sequencer (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_arst_n,
  input  wire logic                   i_sleep_req_n,
  input  wire logic [1:0]             i_pd_mode,
  input  wire logic                   i_panel_mode,
  input  wire logic                   i_display_type,
  input  wire panel_power_pkg::host_t i_host,
  input  wire panel_power_pkg::mem_t  i_mem,
  input  wire panel_power_pkg::panel_t i_panel,
  input  wire panel_power_pkg::dac_t  i_dac,
  output var  panel_power_pkg::host_t o_host,
  output var  panel_power_pkg::mem_t  o_mem,
  output var  panel_power_pkg::panel_t o_panel,
  output var  panel_power_pkg::dac_t  o_dac,
  output var  logic                   o_panel_select_n,
  output var  logic                   o_display_type_out,
  output var  logic                   o_in_power_down
);

  // ----------------------------------------------------------------
  // Sleep request synchronisation and state
  // ----------------------------------------------------------------
  logic                       sleep_n_sync;
  panel_power_pkg::pd_state_t state;
  panel_power_pkg::pd_state_t next_state;
  logic [1:0]                 mode;
  logic [1:0]                 next_mode;

  level_sync #(
    .STAGES    (panel_power_pkg::SYNC_STAGES),
    .RST_VALUE (panel_power_pkg::SLEEP_REQ_RST)
  ) u_sleep_sync (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_async   (i_sleep_req_n),
    .o_sync    (sleep_n_sync)
  );

  always_comb begin
    next_state = state;
    case (state)
      panel_power_pkg::ST_RUN: begin
        if (!sleep_n_sync) begin
          next_state = panel_power_pkg::ST_DOWN;
        end
      end
      panel_power_pkg::ST_DOWN: begin
        if (sleep_n_sync) begin
          next_state = panel_power_pkg::ST_RUN;
        end
      end
      default: begin
        next_state = panel_power_pkg::ST_RUN;
      end
    endcase
  end

  // Mode frozen on entry so a mid-sleep reprogram cannot glitch pins
  assign next_mode = (state == panel_power_pkg::ST_RUN) ? i_pd_mode : mode;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= panel_power_pkg::ST_RUN;
      mode  <= panel_power_pkg::MODE_RST;
    end else begin
      state <= next_state;
      mode  <= next_mode;
    end
  end

  // ----------------------------------------------------------------
  // Output forcing
  // ----------------------------------------------------------------
  wire down     = (state == panel_power_pkg::ST_DOWN);
  wire sys_down = down && (mode == panel_power_pkg::MODE_SYSTEM);

  panel_power_pkg::host_t  next_host;
  panel_power_pkg::mem_t   next_mem;
  panel_power_pkg::panel_t next_panel;
  panel_power_pkg::dac_t   next_dac;

  always_comb begin
    next_host  = i_host;
    next_mem   = i_mem;
    next_panel = i_panel;
    next_dac   = i_dac;
    if (sys_down) begin
      next_host.data_oe               = 1'h0;
      next_mem.video_mem_oe           = 1'h0;
      next_host.iochrdy               = 1'h1;
      next_host.irq                   = 1'h1;
      next_host.memcs16               = 1'h1;
      next_host.bios_rom_enable       = 1'h1;
      next_host.high_byte_buffer_dir  = 1'h1;
      next_host.low_byte_buffer_dir   = 1'h1;
      next_mem.dram_out_enable_upper  = 1'h1;
      next_mem.dram_out_enable_lower  = 1'h1;
      next_mem.write_strobe           = 4'hf;
      next_mem.dram_address           = 9'h1ff;
      next_dac.palette_read_strobe    = 1'h1;
      next_dac.palette_write_strobe   = 1'h1;
      next_dac.pixel_clock            = 1'h0;
    end
    if (down) begin
      // Refresh keeps running, so the RAS/CAS fields are never touched
      next_panel    = '0;
      next_dac.colour = 3'h0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_host             <= panel_power_pkg::HOST_RST;
      o_mem              <= panel_power_pkg::MEM_RST;
      o_panel            <= panel_power_pkg::PANEL_RST;
      o_dac              <= panel_power_pkg::DAC_RST;
      o_panel_select_n   <= panel_power_pkg::PANEL_SEL_RST;
      o_display_type_out <= 1'h0;
    end else begin
      o_host             <= next_host;
      o_mem              <= next_mem;
      o_panel            <= next_panel;
      o_dac              <= next_dac;
      o_panel_select_n   <= !i_panel_mode;
      o_display_type_out <= i_display_type;
    end
  end

  assign o_in_power_down = down;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence sys_down_s;
    state == panel_power_pkg::ST_DOWN && mode == panel_power_pkg::MODE_SYSTEM;
  endsequence

  sequence other_down_s;
    state == panel_power_pkg::ST_DOWN && mode != panel_power_pkg::MODE_SYSTEM;
  endsequence

  sequence any_down_s;
    state == panel_power_pkg::ST_DOWN;
  endsequence

  bus_float_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    sys_down_s |=> !o_host.data_oe && !o_mem.video_mem_oe)
    else $error("data buses not floated in system power-down");

  bus_normal_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    other_down_s |=> o_host == $past(i_host) && o_mem.video_mem_oe == $past(i_mem.video_mem_oe))
    else $error("host bus altered outside system power-down");

  host_ctrl_high_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    sys_down_s |=> o_host.iochrdy && o_host.irq && o_host.memcs16 && o_host.bios_rom_enable
                   && o_host.high_byte_buffer_dir && o_host.low_byte_buffer_dir)
    else $error("host control outputs not high");

  refresh_strobes_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    any_down_s ##1 1'b1 |-> o_mem.row_strobe_upper == $past(i_mem.row_strobe_upper)
      && o_mem.row_strobe_lower == $past(i_mem.row_strobe_lower)
      && o_mem.col_strobe_upper == $past(i_mem.col_strobe_upper)
      && o_mem.col_strobe_lower == $past(i_mem.col_strobe_lower))
    else $error("DRAM strobes disturbed in power-down");

  dram_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    sys_down_s |=> o_mem.dram_out_enable_upper && o_mem.dram_out_enable_lower
                   && o_mem.write_strobe == 4'hf && o_mem.dram_address == 9'h1ff)
    else $error("DRAM controls not held high");

  panel_low_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    any_down_s [*2] |=> o_panel == '0 && o_dac.colour == 3'h0)
    else $error("panel outputs not low in power-down");

  palette_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    sys_down_s |=> o_dac.palette_read_strobe && o_dac.palette_write_strobe && !o_dac.pixel_clock)
    else $error("palette strobes wrong in system power-down");

  display_type_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    1'b1 |=> o_display_type_out == $past(i_display_type))
    else $error("display type output not following selection");

  panel_select_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $rose(i_panel_mode) |=> !o_panel_select_n ##1 (o_panel_select_n == !$past(i_panel_mode)))
    else $error("panel select does not track panel mode");

  select_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    !i_panel_mode [*2] |-> o_panel_select_n)
    else $error("panel select low without panel mode");

  sleep_entry_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (!i_sleep_req_n) [*4] |-> o_in_power_down)
    else $error("sleep request not honoured within three cycles");

endmodule
`default_nettype wire

// File: sim/panel_power_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module panel_power_ctrl (
  input  wire logic i_supplies_stable,
  input  wire logic i_sleep_req_n,
  input  wire logic i_sleep_req,
  input  wire logic i_board_reset,
  input  wire logic i_panel_select_n,
  input  wire logic i_vertical_strobe,
  output var  logic o_panel_power_en_n,
  output var  logic o_backlight_en_n
);
  logic [1:0] frames = 2'h0;
  logic       off;
  // Any power fault or sleep drops both rails at once
  assign off = !i_supplies_stable || !i_sleep_req_n || i_sleep_req || i_board_reset;
  // Two-count frame counter, held clear while deselected or off
  always @(posedge i_vertical_strobe or posedge off or posedge i_panel_select_n) begin
    if (off || i_panel_select_n) begin
      frames <= 2'h0;
    end else if (frames != 2'h2) begin
      frames <= frames + 2'h1;
    end
  end
  assign o_panel_power_en_n = off || i_panel_select_n || frames != 2'h2;
  assign o_backlight_en_n   = off || i_panel_select_n;
endmodule
`default_nettype wire

// File: sim/tb_panel_power_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module tb_panel_power_sequencer;
  logic                    i_sys_clk;
  logic                    i_arst_n;
  logic                    i_sleep_req_n;
  logic [1:0]              i_pd_mode;
  logic                    i_panel_mode;
  logic                    i_display_type;
  logic                    supplies_stable;
  panel_power_pkg::host_t  i_host;
  panel_power_pkg::mem_t   i_mem;
  panel_power_pkg::panel_t i_panel;
  panel_power_pkg::dac_t   i_dac;
  panel_power_pkg::host_t  o_host;
  panel_power_pkg::mem_t   o_mem;
  panel_power_pkg::panel_t o_panel;
  panel_power_pkg::dac_t   o_dac;
  logic                    o_panel_select_n;
  logic                    o_display_type_out;
  logic                    o_in_power_down;
  logic                    panel_power_en_n;
  logic                    backlight_en_n;
  logic [31:0]             seed = 32'h35f98102;
  int                      bad_count = 0;
  int                      total_checks = 0;

  panel_power_sequencer uut (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_sleep_req_n(i_sleep_req_n),
    .i_pd_mode(i_pd_mode), .i_panel_mode(i_panel_mode), .i_display_type(i_display_type), .i_host(i_host),
    .i_mem(i_mem), .i_panel(i_panel), .i_dac(i_dac), .o_host(o_host), .o_mem(o_mem), .o_panel(o_panel),
    .o_dac(o_dac), .o_panel_select_n(o_panel_select_n), .o_display_type_out(o_display_type_out),
    .o_in_power_down(o_in_power_down));

  panel_power_ctrl partner (.i_supplies_stable(supplies_stable), .i_sleep_req_n(i_sleep_req_n),
    .i_sleep_req(!i_sleep_req_n), .i_board_reset(!i_arst_n), .i_panel_select_n(o_panel_select_n),
    .i_vertical_strobe(o_panel.vertical_strobe), .o_panel_power_en_n(panel_power_en_n),
    .o_backlight_en_n(backlight_en_n));

  initial begin
    i_sys_clk = 1'h0;
    forever #50 i_sys_clk = !i_sys_clk;
  end

  function logic [31:0] next_rand();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Inputs still hold what the last edge sampled, so they are the reference
  task automatic check_outs(input bit dn, input bit sys);
    if (dn && sys) begin
      chk(64'(o_host[6:0]), 64'h3f);
      chk(64'(o_mem[35:17]), 64'({i_mem[35:32], 15'h7fff}));
      chk(64'(o_mem[0]), 64'h0);
    end else begin
      chk(64'(o_host), 64'(i_host));
      chk(64'(o_mem), 64'(i_mem));
    end
    chk(64'(o_panel), dn ? 64'h0 : 64'(i_panel));
    chk(64'(o_dac), 64'({dn && sys ? 3'h6 : i_dac[5:3], dn ? 3'h0 : i_dac[2:0]}));
    chk(64'(o_panel_select_n), 64'(!i_panel_mode));
    chk(64'(o_display_type_out), 64'(i_display_type));
    chk(64'(o_in_power_down), 64'(dn));
    chk(64'(backlight_en_n), 64'(!supplies_stable || !i_sleep_req_n || o_panel_select_n));
    if (!supplies_stable || !i_sleep_req_n || o_panel_select_n) chk(64'(panel_power_en_n), 64'h1);
  endtask

  // Pattern 1 all zeros, 2 all ones, else random
  task automatic drive(input int pat, input bit rnd_mode);
    logic [95:0] r;
    r = {next_rand(), next_rand(), next_rand()};
    if (pat == 1) r = '0;
    if (pat == 2) r = '1;
    {i_host, i_mem, i_panel, i_dac, i_panel_mode, i_display_type} = r[79:0];
    if (rnd_mode) i_pd_mode = r[81:80];
  endtask

  task automatic run(input int n, input bit on, input bit dn, input bit sys, input bit rnd_mode);
    for (int k = 0; k < n; k++) begin
      @(posedge i_sys_clk);
      #1;
      if (on) check_outs(dn, sys);
      drive(k < 2 ? k + 1 : 0, rnd_mode);
    end
  endtask

  task automatic do_reset();
    i_arst_n = 1'h0;
    repeat (3) @(posedge i_sys_clk);
    #1;
    chk(64'(o_panel_select_n), 64'h1);
    chk(64'(o_in_power_down), 64'h0);
    chk(64'(panel_power_en_n), 64'h1);
    i_arst_n = 1'h1;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #(100 * 2000);
    bad_count++;
    wrap_up();
  end

  initial begin
    i_arst_n = 1'h0;
    i_sleep_req_n = 1'h1;
    i_pd_mode = 2'h0;
    supplies_stable = 1'h1;
    {i_host, i_mem, i_panel, i_dac, i_panel_mode, i_display_type} = '0;
    do_reset();
    run(20, 1, 0, 0, 1);
    for (int m = 0; m < 4; m++) begin
      i_pd_mode = 2'(m);
      i_sleep_req_n = 1'h0;
      run(5, 0, 0, 0, 0);
      // Mode code is scrambled while asleep; the entry mode must stick
      run(30, 1, 1, m == 0, 1);
      i_sleep_req_n = 1'h1;
      run(5, 0, 0, 0, 1);
      run(20, 1, 0, 0, 1);
    end
    // Reset in mid-sleep, then sleep re-entered with the pin still low
    i_pd_mode = 2'h0;
    i_sleep_req_n = 1'h0;
    run(8, 0, 0, 0, 0);
    do_reset();
    run(5, 0, 0, 0, 0);
    run(10, 1, 1, 1, 1);
    // Awake again, so only the failing supply or a deselected panel can hold the backlight off
    i_sleep_req_n = 1'h1;
    run(5, 0, 0, 0, 1);
    supplies_stable = 1'h0;
    run(10, 1, 0, 0, 1);
    wrap_up();
  end
endmodule
`default_nettype wire
